// *** dv/cfg_tap_asserts.sv ***
`timescale 1ns/1ps
module cfg_tap_asserts
    import cfg_tap_pkg::*;
(
    // core side
    input wire logic                   clk,
    input wire logic                   arst_n,
    input wire logic                   ce,
    input wire logic                   lock_fuse,
    input wire logic                   erase_done,
    input wire logic                   readback_lock_setting_q,
    input wire logic                   wake_done_q,
    input wire logic [WAKE_PHASES-1:0] wake_phase_q,
    input wire logic [WORD_W-1:0]      cfg_wr_word_q,
    input wire logic                   cfg_wr_stb_q,
    // test pins
    input wire logic                   tck,
    input wire logic                   tms,
    input wire logic                   tdo_o,
    input wire logic                   tdo_oe_n
);
    logic       tdo_rise_q;
    logic       oe_rise_q;
    logic [2:0] ones_q;

    // pin values at each rise; a correct port only moves them on the fall
    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tdo_rise_q <= 1'b1;
            oe_rise_q  <= 1'b1;
        end
        else
        begin
            tdo_rise_q <= tdo_o;
            oe_rise_q  <= tdo_oe_n;
        end
    end

    // run of tms ones, saturating at five (reset leaves the tap in reset)
    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
            ones_q <= 3'h5;
        else if (!tms)
            ones_q <= 3'h0;
        else if (ones_q != 3'h5)
            ones_q <= ones_q + 3'h1;
    end

    AST_TDO_ON_FALL: assert property (
        @(negedge tck) disable iff (!arst_n)
        tdo_o == tdo_rise_q && tdo_oe_n == oe_rise_q)
        else $error("tdo moved on a rising tck");
    AST_TLR_QUIET: assert property (
        @(posedge tck) disable iff (!arst_n) ones_q == 3'h5 |-> tdo_oe_n)
        else $error("tdo driven after five tms ones");
    AST_OE_ENTER: assert property (
        @(posedge tck) disable iff (!arst_n) $fell(tdo_oe_n) |-> !$past(tms))
        else $error("tdo enabled without tms low");
    AST_OE_LEAVE: assert property (
        @(posedge tck) disable iff (!arst_n)
        !tdo_oe_n && tms |=> tdo_oe_n)
        else $error("tdo still driven after shift exit");
    AST_STB_PULSE: assert property (
        @(posedge clk) disable iff (!arst_n) cfg_wr_stb_q |=> !cfg_wr_stb_q)
        else $error("write strobe longer than a cycle");
    AST_WORD_STB: assert property (
        @(posedge clk) disable iff (!arst_n)
        $changed(cfg_wr_word_q) |-> cfg_wr_stb_q)
        else $error("write word changed without strobe");
    AST_LOCK_SET: assert property (
        @(posedge clk) disable iff (!arst_n)
        lock_fuse && ce |=> readback_lock_setting_q)
        else $error("lock not set by fuse");
    AST_LOCK_HOLD: assert property (
        @(posedge clk) disable iff (!arst_n)
        !lock_fuse && !erase_done |=> $stable(readback_lock_setting_q))
        else $error("lock changed without fuse or erase");
    AST_LOCK_CLEAR: assert property (
        @(posedge clk) disable iff (!arst_n)
        erase_done && !lock_fuse && ce |=> !readback_lock_setting_q)
        else $error("lock survived erase");
    AST_WAKE_ORDER: assert property (
        @(posedge clk) disable iff (!arst_n)
        $rose(wake_done_q) |-> $past(wake_phase_q[WAKE_PHASES-1]))
        else $error("wake done without last phase");
endmodule : cfg_tap_asserts

bind cfg_tap cfg_tap_asserts u_asserts (.clk, .arst_n, .ce, .lock_fuse,
    .erase_done, .readback_lock_setting_q, .wake_done_q, .wake_phase_q,
    .cfg_wr_word_q, .cfg_wr_stb_q, .tck, .tms, .tdo_o, .tdo_oe_n);

// *** dv/jtag_host.sv ***
`timescale 1ns/1ps
module jtag_host
(
    // test access pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo_o,
    input  wire logic tdo_oe_n
);
    logic tdo_line;
    int   stall;

    // a released tdo floats to its pull-up level
    assign tdo_line = tdo_oe_n ? 1'b1 : tdo_o;

    // tck rests low between frames, as the board pull-down holds it
    initial
    begin
        tck   = 1'b0;
        tms   = 1'b1;
        tdi   = 1'b1;
        stall = 0;
    end

    // one tck period; tms and tdi settle while tck is low
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #(3 + stall);     // a long stall parks tck low
        tck = 1'b1;
        o = tdo_line;     // launched on the previous fall
        #(3 + stall);     // and here parks it high
        tck = 1'b0;
    endtask : step

    // tms pattern lsb first; lines go back to pull-up level afterwards
    task automatic walk(input logic [7:0] m, input int n);
        logic o;
        for (int i = 0; i < n; i++)
            step(m[i], 1'b1, o);
        tms = 1'b1;
        tdi = 1'b1;
    endtask : walk

    task automatic tap_reset();
        walk(8'h1F, 6);   // five ones, then idle
    endtask : tap_reset

    // idle -> shift, n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n,
                        input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        walk(8'h01, 2);
    endtask : scan
endmodule : jtag_host

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb
    import cfg_tap_pkg::*;
;
    localparam logic [31:0] ID  = 32'h0A5A_5001; // arbitrary value
    localparam logic [31:0] TAG = 32'hC3A5_1E69;

    logic              clk, arst_n, tck, tms, tdi, tdo_o, tdo_oe_n;
    logic              lock_fuse, erase_done, load_done, lock_q;
    logic              wake_done, wr_stb;
    logic [WORD_W-1:0] rd_word, wr_word, got;
    logic [7:0]        pin_in, pin_out;
    hold_sel_t         hold_sel;
    pin_ctl_t [7:0]    pin_ctl;
    int                bad_count, num_checks;

    // device under test and the external controller
    cfg_tap #(.PINS(8), .ID_CODE(ID), .USER_TAG(TAG)) u_dut (
        .clk, .arst_n, .ce(1'b1), .tck, .tms, .tdi, .tdo_o, .tdo_oe_n,
        .lock_fuse, .erase_done, .cfg_rd_word(rd_word), .load_done,
        .pin_in, .pin_core_out(pin_out), .hold_sel, .pin_ctl_q(pin_ctl),
        .readback_lock_setting_q(lock_q), .wake_done_q(wake_done),
        .wake_phase_q(), .cfg_wr_word_q(wr_word), .cfg_wr_stb_q(wr_stb));
    jtag_host u_host (.tck, .tms, .tdi, .tdo_o, .tdo_oe_n);

    // 125 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic ir(input logic [7:0] op);
        logic [31:0] o;
        u_host.scan(1'b1, IR_W, {24'h0, op}, o);
        check(o, IR_RESET_VAL);
    endtask : ir

    task automatic dr(input int n, input logic [31:0] din);
        u_host.scan(1'b0, n, din, got);
    endtask : dr

    // one-cycle pulse: 0 lock fuse, 1 erase, 2 load done
    task automatic pulse(input int s);
        @(posedge clk);
        lock_fuse  <= s == 0;
        erase_done <= s == 1;
        load_done  <= s == 2;
        @(posedge clk);
        {lock_fuse, erase_done, load_done} <= 3'b000;
    endtask : pulse

    task automatic pins(output logic [7:0] ov, lv, en);
        for (int k = 0; k < 8; k++)
        begin
            ov[k] = pin_ctl[k].override;
            lv[k] = pin_ctl[k].level;
            en[k] = pin_ctl[k].enable_n;
        end
    endtask : pins

    // identity after reset, bypass path, user tag with a crawling tck
    task automatic t_ident();
        u_host.tap_reset();
        check(tdo_oe_n, 1'b1);
        dr(WORD_W, 32'h0);
        check(got, ID);
        ir(OP_BYPASS);
        dr(8, 32'hA5);
        check(got, 32'h4A);
        u_host.stall = 40;
        ir(OP_USERCODE);
        dr(WORD_W, 32'h0);
        check(got, TAG);
        u_host.stall = 0;
        $display("test ident done");
    endtask : t_ident

    task automatic t_sample();
        logic [7:0] ov, lv, en;
        @(posedge clk);
        pin_in <= 8'h96;
        ir(OP_SAMPLE);
        dr(8, 32'h0);
        check(got, 32'h96);
        ir(OP_EXTEST);
        dr(8, 32'h3C);
        check(got, 32'h96);
        repeat (4) @(posedge clk);
        pins(ov, lv, en);
        check({ov, lv}, 16'hFF3C);
        $display("test sample done");
    endtask : t_sample

    // every hold choice while a configuration word is written
    task automatic t_write();
        logic [7:0] ov, lv, en;
        pin_out <= 8'h5C;
        for (int h = 0; h < 4; h++)
        begin
            @(posedge clk);
            hold_sel <= hold_sel_t'(h);
            ir(OP_CFG_WRITE);
            dr(WORD_W, 32'h1234_AB00 + h);
            for (int i = 0; i < 40 && wr_stb !== 1'b1; i++)
                @(posedge clk);
            check(wr_stb, 1'b1);
            check(wr_word, 32'h1234_AB00 + h);
            pins(ov, lv, en);
            check(ov, 8'hFF);
            check(h == 0 ? en : lv, h < 2 ? 8'hFF : h == 2 ? 8'h00 : 8'h5C);
        end
        $display("test write done");
    endtask : t_write

    task automatic t_lock();
        logic [7:0] ov, lv, en;
        @(posedge clk);
        rd_word <= 32'h5A5A_C3C3;
        ir(OP_CFG_READ);
        dr(WORD_W, 32'h0);
        check(got, 32'h5A5A_C3C3);
        pins(ov, lv, en);
        check(ov, 8'h00);
        pulse(0);
        ir(OP_CFG_READ);
        dr(WORD_W, 32'h0);
        check(got, 32'h0);
        ir(OP_STATUS);
        dr(WORD_W, 32'h0);
        check(got[1:0], 2'b11);
        ir(OP_USERCODE);
        dr(WORD_W, 32'h0);
        check(got, TAG);
        ir(OP_CFG_WRITE);
        dr(WORD_W, 32'hFFFF_FFFF);
        repeat (8) @(posedge clk);
        check(lock_q, 1'b1);
        pulse(1);
        ir(OP_CFG_READ);
        dr(WORD_W, 32'h0);
        check(lock_q, 1'b0);
        check(got, 32'h5A5A_C3C3);
        $display("test lock done");
    endtask : t_lock

    task automatic t_wake();
        int n;
        ir(OP_STATUS);   // a live configuration write would abort wake-up
        repeat (4) @(posedge clk); // write level must clear its sync first
        pulse(2);
        n = 0;
        while (wake_done !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        check(n >= WAKE_PHASES * WAKE_PHASE_CYC && n <= 32, 1'b1);
        dr(WORD_W, 32'h0);
        check(got[2:0], 3'b101);
        $display("test wake done");
    endtask : t_wake

    // reset with tck edges inside it, then the scenarios
    initial
    begin
        {arst_n, lock_fuse, erase_done, load_done} = 4'h0;
        {rd_word, pin_in, pin_out} = '0;
        hold_sel = HOLD_TRISTATE;
        bad_count = 0;
        num_checks = 0;
        u_host.tap_reset();
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_ident();
        t_sample();
        t_write();
        t_lock();
        t_wake();
        end_of_test();
    end

    // the scenarios need under 10 us; twenty times that means a hang
    initial
    begin
        #200000;
        bad_count++;
        end_of_test();
    end
endmodule : tb

// *** rtl/cfg_tap.sv ***
// Operation
// - tdo changes on falling tck edge
// - tdo tristated unless shifting
// - tdi sampled on rising tck edge
// - tap state follows tms each rise
// - tck may halt high or low
// - port always live, config independent
// - lock refuses configuration readback
// - id, user tag, status stay readable
// - 32-bit user tag register provided
// - user tag shifts out via data path
// - wake-up sequenced on internal clock
// - boundary chain covers every user pin
// - locked readback returns all zeros
// - pins held per cell during write
// - readback leaves user logic undisturbed
// - lock clears only by erase (arst_n also clears it here)
`timescale 1ns/1ps
module cfg_tap
    import cfg_tap_pkg::*;
#(
    parameter int          PINS      = 8,
    parameter logic [31:0] ID_CODE   = 32'h0A5A_5001, // arbitrary value
    parameter logic [31:0] USER_TAG  = 32'h0000_0000
)
(
    // core clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              ce,
    // test access pins
    input  wire logic              tck,
    input  wire logic              tms,
    input  wire logic              tdi,
    output logic                   tdo_o,
    output logic                   tdo_oe_n,
    // configuration memory side
    input  wire logic              lock_fuse,
    input  wire logic              erase_done,
    input  wire logic [WORD_W-1:0] cfg_rd_word,
    input  wire logic              load_done,
    // user pins seen and held by boundary cells
    input  wire logic [PINS-1:0]   pin_in,
    input  wire logic [PINS-1:0]   pin_core_out,
    input  wire hold_sel_t         hold_sel,
    output pin_ctl_t [PINS-1:0]    pin_ctl_q,
    // status to core
    output logic                   readback_lock_setting_q,
    output logic                   wake_done_q,
    output logic [WAKE_PHASES-1:0] wake_phase_q,
    output logic [WORD_W-1:0]      cfg_wr_word_q,
    output logic                   cfg_wr_stb_q
);

    logic st_reset, st_idle, st_cap_dr, st_sh_dr, st_upd_dr;
    logic st_cap_ir, st_sh_ir, st_upd_ir;

    // controller lives on tck alone, regardless of configuration
    tap_fsm u_fsm
    (
        .tck       (tck),
        .trst_n    (arst_n),
        .tms       (tms),
        .st_reset  (st_reset),
        .st_idle   (st_idle),
        .st_cap_dr (st_cap_dr),
        .st_sh_dr  (st_sh_dr),
        .st_upd_dr (st_upd_dr),
        .st_cap_ir (st_cap_ir),
        .st_sh_ir  (st_sh_ir),
        .st_upd_ir (st_upd_ir)
    );

    // lock bit crosses into tck domain through two flops
    logic lock_s1_q;
    logic lock_s2_q;
    logic wake_s1_q;
    logic wake_s2_q;
    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
        end
        else
        begin
            lock_s1_q <= readback_lock_setting_q;
            lock_s2_q <= lock_s1_q;
        end
    end

    // instruction register
    logic [IR_W-1:0] ir_sh_q;
    logic [IR_W-1:0] ir_q;
    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ir_sh_q <= IR_RESET_VAL;
            ir_q    <= OP_IDCODE;
        end
        else if (st_reset)
            ir_q <= OP_IDCODE;
        else if (st_cap_ir)
            ir_sh_q <= IR_RESET_VAL;
        else if (st_sh_ir)
            ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
        else if (st_upd_ir)
            ir_q <= ir_sh_q;
    end

    // pin samples cross into tck domain before capture
    logic [PINS-1:0] pin_s1_q;
    logic [PINS-1:0] pin_s2_q;
    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // capture value chosen by instruction; locked readback gives zeros
    logic [WORD_W-1:0] cap_word;
    always_comb
    begin
        cap_word = '0;
        unique case (ir_q)
            OP_IDCODE:   cap_word = ID_CODE;
            OP_USERCODE: cap_word = USER_TAG;
            OP_STATUS:   cap_word = {{(WORD_W-3){1'b0}},
                                     wake_s2_q, lock_s2_q, 1'b1};
            OP_CFG_READ: cap_word = lock_s2_q ? '0 : cfg_rd_word;
            default:     cap_word = '0;
        endcase
    end

    // one cell per user pin; word shift serves id, tag, status and config; bypass keeps its own bit
    logic [PINS-1:0]   bsr_sh_q;
    logic [PINS-1:0]   bsr_upd_q;
    logic [WORD_W-1:0] dr_sh_q;
    logic              byp_q;
    logic              use_bsr;
    logic              use_word;
    assign use_bsr  = (ir_q == OP_EXTEST) || (ir_q == OP_SAMPLE);
    assign use_word = (ir_q == OP_IDCODE) || (ir_q == OP_USERCODE)
                   || (ir_q == OP_STATUS) || (ir_q == OP_CFG_READ)
                   || (ir_q == OP_CFG_WRITE);

    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bsr_sh_q  <= '0;
            bsr_upd_q <= '0;
            dr_sh_q   <= '0;
            byp_q     <= 1'b0;
        end
        else if (st_cap_dr)
        begin
            bsr_sh_q <= pin_s2_q;
            dr_sh_q  <= cap_word;
            byp_q    <= 1'b0;
        end
        else if (st_sh_dr)
        begin
            if (use_bsr)
                bsr_sh_q <= {tdi, bsr_sh_q[PINS-1:1]};
            else if (use_word)
                dr_sh_q <= {tdi, dr_sh_q[WORD_W-1:1]};
            else
                byp_q <= tdi;
        end
        else if (st_upd_dr && use_bsr)
            bsr_upd_q <= bsr_sh_q;
    end

    // write word handed over by toggle; readback only observes
    logic              wr_tgl_q;
    logic [WORD_W-1:0] wr_hold_q;
    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_tgl_q  <= 1'b0;
            wr_hold_q <= '0;
        end
        else if (st_upd_dr && ir_q == OP_CFG_WRITE)
        begin
            wr_tgl_q  <= ~wr_tgl_q;
            wr_hold_q <= dr_sh_q;
        end
    end

    // mode levels for the core domain
    logic in_write;
    logic in_extest;
    assign in_write  = (ir_q == OP_CFG_WRITE);
    assign in_extest = (ir_q == OP_EXTEST);

    // tdo launched on the falling edge, released outside shift
    logic sel_bit;
    assign sel_bit = st_sh_ir ? ir_sh_q[0]
                   : use_bsr  ? bsr_sh_q[0]
                   : use_word ? dr_sh_q[0] : byp_q;
    always_ff @(negedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tdo_o    <= 1'b1;
            tdo_oe_n <= 1'b1;
        end
        else
        begin
            tdo_o    <= sel_bit;
            tdo_oe_n <= !(st_sh_ir || st_sh_dr);
        end
    end

    // core domain: synchronise mode levels and the write toggle
    logic [2:0] mode_s1_q;
    logic [2:0] mode_s2_q;
    logic       tgl_s3_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_s1_q <= '0;
            mode_s2_q <= '0;
            tgl_s3_q  <= 1'b0;
        end
        else if (ce)
        begin
            mode_s1_q <= {wr_tgl_q, in_extest, in_write};
            mode_s2_q <= mode_s1_q;
            tgl_s3_q  <= mode_s2_q[2];
        end
    end

    // word held stable by toggle protocol before being sampled here
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_wr_word_q <= '0;
            cfg_wr_stb_q  <= 1'b0;
        end
        else if (ce)
        begin
            cfg_wr_stb_q <= mode_s2_q[2] ^ tgl_s3_q;
            if (mode_s2_q[2] ^ tgl_s3_q)
                cfg_wr_word_q <= wr_hold_q;
        end
    end

    // lock is sticky; only an erase of its memory space or the async reset clears it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            readback_lock_setting_q <= 1'b0;       // default off
        else if (ce)
        begin
            if (lock_fuse)
                readback_lock_setting_q <= 1'b1;   // set wins over erase
            else if (erase_done)
                readback_lock_setting_q <= 1'b0;
        end
    end

    // boundary update bits cross as slowly changing levels
    logic [PINS-1:0] upd_s1_q;
    logic [PINS-1:0] upd_s2_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            upd_s1_q <= '0;
            upd_s2_q <= '0;
        end
        else if (ce)
        begin
            upd_s1_q <= bsr_upd_q;
            upd_s2_q <= upd_s1_q;
        end
    end

    // pin hold during configuration write; tristate is default
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++)
        begin : g_pin
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    pin_ctl_q[gi] <= '{1'b0, 1'b0, 1'b1};
                else if (ce)
                begin
                    if (mode_s2_q[0])
                    begin
                        unique case (hold_sel)
                            HOLD_HIGH:
                                pin_ctl_q[gi] <= '{1'b1, 1'b1, 1'b0};
                            HOLD_LOW:
                                pin_ctl_q[gi] <= '{1'b1, 1'b0, 1'b0};
                            HOLD_CURRENT:
                                pin_ctl_q[gi] <=
                                    '{1'b1, pin_core_out[gi], 1'b0};
                            default:
                                pin_ctl_q[gi] <= '{1'b1, 1'b0, 1'b1};
                        endcase
                    end
                    else if (mode_s2_q[1])
                        pin_ctl_q[gi] <= '{1'b1, upd_s2_q[gi], 1'b0};
                    else
                        pin_ctl_q[gi] <= '{1'b0, 1'b0, 1'b1};
                end
            end
        end
    endgenerate

    // wake-up after loading, halted again by a new write
    wake_seq u_wake
    (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .start   (load_done),
        .abort   (mode_s2_q[0]),
        .phase_q (wake_phase_q),
        .done_q  (wake_done_q)
    );

    // wake status back into tck domain for the status register
    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
        end
        else
        begin
            wake_s1_q <= wake_done_q;
            wake_s2_q <= wake_s1_q;
        end
    end

endmodule : cfg_tap

// *** rtl/cfg_tap_pkg.sv ***
package cfg_tap_pkg;

    // instruction register
    localparam int          IR_W           = 8;
    localparam logic [7:0]  IR_RESET_VAL   = 8'h01;   // capture pattern 01
    localparam logic [7:0]  OP_EXTEST      = 8'h00;
    localparam logic [7:0]  OP_IDCODE      = 8'h16;
    localparam logic [7:0]  OP_SAMPLE      = 8'h1C;
    localparam logic [7:0]  OP_USERCODE    = 8'h17;
    localparam logic [7:0]  OP_CFG_WRITE   = 8'h3A;
    localparam logic [7:0]  OP_CFG_READ    = 8'h73;
    localparam logic [7:0]  OP_STATUS      = 8'hB2;
    localparam logic [7:0]  OP_BYPASS      = 8'hFF;

    // data register width, reset run of ones and sync depth
    localparam int          WORD_W         = 32;
    localparam int          TLR_ONES       = 5;
    localparam int          SYNC_STAGES    = 2;

    // wake-up sequencing on the core clock
    localparam int          CLK_MHZ        = 125;
    localparam int          WAKE_PHASE_NS  = 64;
    localparam int          WAKE_PHASE_CYC = (WAKE_PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam int          WAKE_PHASES    = 3;

    // boundary cell hold choice during configuration write
    typedef enum logic [1:0]
    {
        HOLD_TRISTATE = 2'h0,
        HOLD_HIGH     = 2'h1,
        HOLD_LOW      = 2'h2,
        HOLD_CURRENT  = 2'h3
    } hold_sel_t;

    // pin bundle driven toward the pad ring
    typedef struct packed
    {
        logic override;   // boundary cells own the pins
        logic level;
        logic enable_n;   // low while driving
    } pin_ctl_t;

    // serial outputs from the tap domain
    typedef struct packed
    {
        logic tdo_o;
        logic tdo_oe_n;
    } tdo_pin_t;

endpackage : cfg_tap_pkg

// *** rtl/tap_fsm.sv ***
`timescale 1ns/1ps
module tap_fsm
    import cfg_tap_pkg::*;
(
    // test clock domain
    input  wire logic tck,
    input  wire logic trst_n,
    input  wire logic tms,
    // decoded state
    output logic      st_reset,
    output logic      st_idle,
    output logic      st_cap_dr,
    output logic      st_sh_dr,
    output logic      st_upd_dr,
    output logic      st_cap_ir,
    output logic      st_sh_ir,
    output logic      st_upd_ir
);

    typedef enum logic [15:0]
    {
        S_TLR   = 16'h0001, S_RTI   = 16'h0002, S_SELDR = 16'h0004,
        S_CAPDR = 16'h0008, S_SHDR  = 16'h0010, S_EX1DR = 16'h0020,
        S_PADR  = 16'h0040, S_EX2DR = 16'h0080, S_UPDR  = 16'h0100,
        S_SELIR = 16'h0200, S_CAPIR = 16'h0400, S_SHIR  = 16'h0800,
        S_EX1IR = 16'h1000, S_PAIR  = 16'h2000, S_EX2IR = 16'h4000,
        S_UPIR  = 16'h8000
    } tap_st_t;

    tap_st_t st_q;
    tap_st_t st_d;

    // sixteen-state walk steered by tms; five ones reach reset
    always_comb
    begin
        unique case (st_q)
            S_TLR:   st_d = tms ? S_TLR   : S_RTI;
            S_RTI:   st_d = tms ? S_SELDR : S_RTI;
            S_SELDR: st_d = tms ? S_SELIR : S_CAPDR;
            S_CAPDR: st_d = tms ? S_EX1DR : S_SHDR;
            S_SHDR:  st_d = tms ? S_EX1DR : S_SHDR;
            S_EX1DR: st_d = tms ? S_UPDR  : S_PADR;
            S_PADR:  st_d = tms ? S_EX2DR : S_PADR;
            S_EX2DR: st_d = tms ? S_UPDR  : S_SHDR;
            S_UPDR:  st_d = tms ? S_SELDR : S_RTI;
            S_SELIR: st_d = tms ? S_TLR   : S_CAPIR;
            S_CAPIR: st_d = tms ? S_EX1IR : S_SHIR;
            S_SHIR:  st_d = tms ? S_EX1IR : S_SHIR;
            S_EX1IR: st_d = tms ? S_UPIR  : S_PAIR;
            S_PAIR:  st_d = tms ? S_EX2IR : S_PAIR;
            S_EX2IR: st_d = tms ? S_UPIR  : S_SHIR;
            S_UPIR:  st_d = tms ? S_SELDR : S_RTI;
            default: st_d = S_TLR;
        endcase
    end

    // static logic: tck may stop at either level indefinitely
    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            st_q <= S_TLR;
        else
            st_q <= st_d;
    end

    assign st_reset  = (st_q == S_TLR);
    assign st_idle   = (st_q == S_RTI);
    assign st_cap_dr = (st_q == S_CAPDR);
    assign st_sh_dr  = (st_q == S_SHDR);
    assign st_upd_dr = (st_q == S_UPDR);
    assign st_cap_ir = (st_q == S_CAPIR);
    assign st_sh_ir  = (st_q == S_SHIR);
    assign st_upd_ir = (st_q == S_UPIR);

endmodule : tap_fsm

// *** rtl/wake_seq.sv ***
`timescale 1ns/1ps
module wake_seq
    import cfg_tap_pkg::*;
#(
    parameter int PHASES    = WAKE_PHASES,
    parameter int PHASE_CYC = WAKE_PHASE_CYC
)
(
    // core clock
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              ce,
    // control
    input  wire logic              start,
    input  wire logic              abort,
    // progress
    output logic [PHASES-1:0]      phase_q,
    output logic                   done_q
);

    localparam int CW = $clog2(PHASE_CYC + 1);

    logic [CW-1:0] cnt_q;

    // fixed-length phases on the core clock, never on tck
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q   <= '0;
            phase_q <= '0;
            done_q  <= 1'b0;
        end
        else if (ce)
        begin
            if (abort)
            begin
                cnt_q   <= '0;
                phase_q <= '0;
                done_q  <= 1'b0;
            end
            else if (start && !done_q && phase_q == '0)
            begin
                phase_q <= PHASES'(1);
                cnt_q   <= '0;
            end
            else if (phase_q != '0)
            begin
                if (cnt_q == CW'(PHASE_CYC - 1))
                begin
                    cnt_q   <= '0;
                    phase_q <= phase_q << 1;   // one phase at a time
                    if (phase_q[PHASES-1])
                        done_q <= 1'b1;
                end
                else
                    cnt_q <= cnt_q + CW'(1);
            end
        end
    end

endmodule : wake_seq
